// file: hw/rac_alarm_flags.sv
// Top of the alarm compare, carry flag and interrupt request block
//
// Summary of operation
// RL1: Compare only enabled fields; all must match.
// RL2: Software loads minute alarm 00..59 BCD.
// RL3: Hour alarm 00..23 BCD; bit 6 reads 0.
// RL4: Weekday alarm 0..6 in bits 2..0.
// RL5: Date alarm 01..31 BCD; bit 6 reads 0.
// RL6: Month alarm 01..12 BCD; bits 6..5 zero.
// RL7: Power-on clears enables; values never reset.
// RL8: Control register zero on power-on; manual keeps carry.
// RL9: Carry flag sets on 64 Hz/seconds count.
// RL10: Writing 0 clears carry; 1 sets it.
// RL11: Carry interrupt while carry flag and enable.
// RL12: Alarm interrupt while alarm flag and enable.
// RL13: Match sets alarm flag; write 0 clears.
// RL14: Reserved control bits read zero.
// RL15: Software avoids read-modify-write of control register.
// RL16: Software rereads counters when carry sets.
// RL17: Software initialises carry flag before use.
// RL18: Seconds alarm joins compare; power-on clears enable.
// RL19: Match checked per update; flag stays sticky.
`timescale 1ns/1ps
module rac_alarm_flags
	import rac_pkg::*;
(
	// Clock and power-on reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Manual reset, synchronous, active high
	input  wire logic        manual_rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Running BCD time counters
	input  wire logic [7:0]  seconds_counter_i,
	input  wire logic [7:0]  minutes_counter_i,
	input  wire logic [7:0]  hours_counter_i,
	input  wire logic [7:0]  weekday_counter_i,
	input  wire logic [7:0]  date_counter_i,
	input  wire logic [7:0]  month_counter_i,
	// Count-up events of the counter chain, one-cycle pulses
	input  wire logic        sixty_four_hz_count_i,
	input  wire logic        seconds_count_i,
	// Interrupt requests
	output logic             carry_irq_o,
	output logic             alarm_irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////////////////

	logic        req_first;
	logic        req_done;
	logic        wr_stb;
	logic        lane0_wr;
	logic [7:0]  wdata;
	logic [7:0]  rdata_next;
	logic [31:0] dat_reg;

	logic        sel_sec;
	logic        sel_min;
	logic        sel_hour;
	logic        sel_wday;
	logic        sel_date;
	logic        sel_mon;
	logic        sel_ctrl;

	logic [7:0]  rd_sec;
	logic [7:0]  rd_min;
	logic [7:0]  rd_hour;
	logic [7:0]  rd_wday;
	logic [7:0]  rd_date;
	logic [7:0]  rd_mon;
	logic [7:0]  rd_ctrl;

	logic [RAC_NUM_FIELDS-1:0] field_on;
	logic [RAC_NUM_FIELDS-1:0] field_match;

	logic        carry_flag_reg;
	logic        carry_irq_on_reg;
	logic        alarm_irq_on_reg;
	logic        alarm_flag_reg;
	logic        update_seen_reg;
	logic        alarm_hit;
	logic        carry_event;
	logic        ctrl_wr;
	logic        carry_irq_reg;
	logic        alarm_irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake and decode
	////////////////////////////////////////////////////////////////////////////

	// Registered ack, one wait state
	rac_wb_slave u_wb (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.wb_cyc_i    (wb_cyc_i),
		.wb_stb_i    (wb_stb_i),
		.wb_ack_o    (wb_ack_o),
		.req_first_o (req_first),
		.req_done_o  (req_done)
	);

	// Writes land at the edge where the master samples ack
	assign wr_stb   = req_done && wb_we_i;
	assign lane0_wr = wr_stb && wb_sel_i[0];
	assign wdata    = wb_dat_i[7:0];

	// Address decode on whole words
	assign sel_sec  = (wb_adr_i[7:2] == RAC_OFS_SEC_ALARM[7:2]);
	assign sel_min  = (wb_adr_i[7:2] == RAC_OFS_MIN_ALARM[7:2]);
	assign sel_hour = (wb_adr_i[7:2] == RAC_OFS_HOUR_ALARM[7:2]);
	assign sel_wday = (wb_adr_i[7:2] == RAC_OFS_WDAY_ALARM[7:2]);
	assign sel_date = (wb_adr_i[7:2] == RAC_OFS_DATE_ALARM[7:2]);
	assign sel_mon  = (wb_adr_i[7:2] == RAC_OFS_MON_ALARM[7:2]);
	assign sel_ctrl = (wb_adr_i[7:2] == RAC_OFS_FLAG_CTRL[7:2]);

	////////////////////////////////////////////////////////////////////////////
	// Alarm field registers
	////////////////////////////////////////////////////////////////////////////

	// RL18: seconds alarm field
	rac_field_cmp #(.VALUE_MASK(RAC_MASK_SEC)) u_sec (
		.clk_i     (clk_i),
		.por_i     (rst_i),
		.wr_i      (lane0_wr && sel_sec),
		.wdata_i   (wdata),
		.count_i   (seconds_counter_i),
		.rdata_o   (rd_sec),
		.enabled_o (field_on[0]),
		.match_o   (field_match[0])
	);

	// RL2: minute alarm field
	rac_field_cmp #(.VALUE_MASK(RAC_MASK_MIN)) u_min (
		.clk_i     (clk_i),
		.por_i     (rst_i),
		.wr_i      (lane0_wr && sel_min),
		.wdata_i   (wdata),
		.count_i   (minutes_counter_i),
		.rdata_o   (rd_min),
		.enabled_o (field_on[1]),
		.match_o   (field_match[1])
	);

	// RL3: hour alarm field, bit 6 read-only
	rac_field_cmp #(.VALUE_MASK(RAC_MASK_HOUR)) u_hour (
		.clk_i     (clk_i),
		.por_i     (rst_i),
		.wr_i      (lane0_wr && sel_hour),
		.wdata_i   (wdata),
		.count_i   (hours_counter_i),
		.rdata_o   (rd_hour),
		.enabled_o (field_on[2]),
		.match_o   (field_match[2])
	);

	// RL4: weekday alarm field, bits 6..3 read-only
	rac_field_cmp #(.VALUE_MASK(RAC_MASK_WDAY)) u_wday (
		.clk_i     (clk_i),
		.por_i     (rst_i),
		.wr_i      (lane0_wr && sel_wday),
		.wdata_i   (wdata),
		.count_i   (weekday_counter_i),
		.rdata_o   (rd_wday),
		.enabled_o (field_on[3]),
		.match_o   (field_match[3])
	);

	// RL5: date alarm field, bit 6 read-only
	rac_field_cmp #(.VALUE_MASK(RAC_MASK_DATE)) u_date (
		.clk_i     (clk_i),
		.por_i     (rst_i),
		.wr_i      (lane0_wr && sel_date),
		.wdata_i   (wdata),
		.count_i   (date_counter_i),
		.rdata_o   (rd_date),
		.enabled_o (field_on[4]),
		.match_o   (field_match[4])
	);

	// RL6: month alarm field, bits 6..5 read-only
	rac_field_cmp #(.VALUE_MASK(RAC_MASK_MON)) u_mon (
		.clk_i     (clk_i),
		.por_i     (rst_i),
		.wr_i      (lane0_wr && sel_mon),
		.wdata_i   (wdata),
		.count_i   (month_counter_i),
		.rdata_o   (rd_mon),
		.enabled_o (field_on[5]),
		.match_o   (field_match[5])
	);

	////////////////////////////////////////////////////////////////////////////
	// Alarm detection
	////////////////////////////////////////////////////////////////////////////

	// Delay the seconds update by one cycle so counters have settled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			update_seen_reg <= 1'b0;
		end else begin
			update_seen_reg <= seconds_count_i;
		end
	end

	// RL1: every enabled field equal, at least one enabled
	// RL19: evaluated once per time update
	assign alarm_hit = update_seen_reg && (|field_on) && (&field_match);

	////////////////////////////////////////////////////////////////////////////
	// Flag and interrupt control register
	////////////////////////////////////////////////////////////////////////////

	assign ctrl_wr     = lane0_wr && sel_ctrl;
	assign carry_event = sixty_four_hz_count_i || seconds_count_i;

	// RL9: carry flag set by count-up, set beats clear
	// RL10: write 0 clears, write 1 sets
	// RL8: manual reset leaves carry flag as it was
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry_flag_reg <= RAC_FLAG_CTRL_RESET[RAC_BIT_CARRY_FLAG];
		end else if (carry_event) begin
			carry_flag_reg <= 1'b1;
		end else if (ctrl_wr) begin
			carry_flag_reg <= wdata[RAC_BIT_CARRY_FLAG];
		end
	end

	// RL13: alarm flag sticky, write 0 clears, set beats clear
	// RL8: manual reset clears it
	always_ff @(posedge clk_i) begin
		if (rst_i || manual_rst_i) begin
			alarm_flag_reg <= RAC_FLAG_CTRL_RESET[RAC_BIT_ALARM_FLAG];
		end else if (alarm_hit) begin
			alarm_flag_reg <= 1'b1;
		end else if (ctrl_wr && !wdata[RAC_BIT_ALARM_FLAG]) begin
			alarm_flag_reg <= 1'b0;
		end
	end

	// RL8: interrupt enables cleared by either reset
	always_ff @(posedge clk_i) begin
		if (rst_i || manual_rst_i) begin
			carry_irq_on_reg <= RAC_FLAG_CTRL_RESET[RAC_BIT_CARRY_IRQ_ON];
			alarm_irq_on_reg <= RAC_FLAG_CTRL_RESET[RAC_BIT_ALARM_IRQ_ON];
		end else if (ctrl_wr) begin
			carry_irq_on_reg <= wdata[RAC_BIT_CARRY_IRQ_ON];
			alarm_irq_on_reg <= wdata[RAC_BIT_ALARM_IRQ_ON];
		end
	end

	// RL14: reserved bits read zero
	always_comb begin
		rd_ctrl                       = 8'h00;
		rd_ctrl[RAC_BIT_CARRY_FLAG]   = carry_flag_reg;
		rd_ctrl[RAC_BIT_CARRY_IRQ_ON] = carry_irq_on_reg;
		rd_ctrl[RAC_BIT_ALARM_IRQ_ON] = alarm_irq_on_reg;
		rd_ctrl[RAC_BIT_ALARM_FLAG]   = alarm_flag_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt requests
	////////////////////////////////////////////////////////////////////////////

	// RL11: carry request follows flag and enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry_irq_reg <= 1'b0;
		end else begin
			carry_irq_reg <= carry_flag_reg && carry_irq_on_reg;
		end
	end

	// RL12: alarm request follows flag and enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_irq_reg <= 1'b0;
		end else begin
			alarm_irq_reg <= alarm_flag_reg && alarm_irq_on_reg;
		end
	end

	assign carry_irq_o = carry_irq_reg;
	assign alarm_irq_o = alarm_irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Read data path
	////////////////////////////////////////////////////////////////////////////

	// Read mux; unmapped words read zero
	always_comb begin
		rdata_next = 8'h00;
		case (1'b1)
			sel_sec:  rdata_next = rd_sec;
			sel_min:  rdata_next = rd_min;
			sel_hour: rdata_next = rd_hour;
			sel_wday: rdata_next = rd_wday;
			sel_date: rdata_next = rd_date;
			sel_mon:  rdata_next = rd_mon;
			sel_ctrl: rdata_next = rd_ctrl;
			default:  rdata_next = 8'h00;
		endcase
	end

	// Read data captured with the ack, upper bits zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 32'h0000_0000;
		end else if (req_first && !wb_we_i) begin
			dat_reg <= {24'h00_0000, rdata_next};
		end else if (req_first) begin
			dat_reg <= 32'h0000_0000;
		end
	end

	assign wb_dat_o = dat_reg;

endmodule : rac_alarm_flags

// file: common/rac_pkg.sv
// Package of offsets, field layouts and reset values for the alarm compare and flag block
package rac_pkg;

	// Register byte offsets on the bus (one aligned word each)
	localparam logic [7:0] RAC_OFS_SEC_ALARM  = 8'h00;
	localparam logic [7:0] RAC_OFS_MIN_ALARM  = 8'h04;
	localparam logic [7:0] RAC_OFS_HOUR_ALARM = 8'h08;
	localparam logic [7:0] RAC_OFS_WDAY_ALARM = 8'h0C;
	localparam logic [7:0] RAC_OFS_DATE_ALARM = 8'h10;
	localparam logic [7:0] RAC_OFS_MON_ALARM  = 8'h14;
	localparam logic [7:0] RAC_OFS_FLAG_CTRL  = 8'h18;

	// Compare enable position in every alarm register
	localparam int unsigned RAC_BIT_COMPARE_ON = 7;

	// Writable value bits of each alarm register, enable bit excluded
	localparam logic [6:0] RAC_MASK_SEC  = 7'h7F;
	localparam logic [6:0] RAC_MASK_MIN  = 7'h7F;
	localparam logic [6:0] RAC_MASK_HOUR = 7'h3F;
	localparam logic [6:0] RAC_MASK_WDAY = 7'h07;
	localparam logic [6:0] RAC_MASK_DATE = 7'h3F;
	localparam logic [6:0] RAC_MASK_MON  = 7'h1F;

	// Flag and interrupt control register layout
	localparam int unsigned RAC_BIT_CARRY_FLAG   = 7;
	localparam int unsigned RAC_BIT_CARRY_IRQ_ON = 4;
	localparam int unsigned RAC_BIT_ALARM_IRQ_ON = 3;
	localparam int unsigned RAC_BIT_ALARM_FLAG   = 0;
	localparam logic [7:0]  RAC_FLAG_CTRL_RESET  = 8'h00;

	// Number of alarm fields
	localparam int unsigned RAC_NUM_FIELDS = 6;

endpackage : rac_pkg

// file: hw/rac_field_cmp.sv
// One alarm field register with its compare against a time counter
`timescale 1ns/1ps
module rac_field_cmp
	import rac_pkg::*;
#(
	parameter logic [6:0] VALUE_MASK = 7'h7F
) (
	// Clock and power-on reset
	input  wire logic       clk_i,
	input  wire logic       por_i,
	// Register write port
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	// Running counter value
	input  wire logic [7:0] count_i,
	// Read-back and compare result
	output logic      [7:0] rdata_o,
	output logic            enabled_o,
	output logic            match_o
);

	logic       compare_on_reg;
	logic [6:0] value_reg;

	// RL7: enable cleared on power-on
	// Enable bit: of the two resets, cleared by power-on reset only
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			compare_on_reg <= 1'b0;
		end else if (wr_i) begin
			compare_on_reg <= wdata_i[RAC_BIT_COMPARE_ON];
		end
	end

	// Value bits: no reset, kept through manual and power-on reset
	always_ff @(posedge clk_i) begin
		if (wr_i) begin
			value_reg <= wdata_i[6:0] & VALUE_MASK;
		end
	end

	// Read-only bits read zero
	assign rdata_o   = {compare_on_reg, value_reg & VALUE_MASK};
	assign enabled_o = compare_on_reg;

	// RL1: masked field compare
	assign match_o = !compare_on_reg || ((value_reg & VALUE_MASK) == (count_i[6:0] & VALUE_MASK));

endmodule : rac_field_cmp

// file: hw/rac_wb_slave.sv
// Classic Wishbone slave handshake: one request strobe and a registered ack
`timescale 1ns/1ps
module rac_wb_slave (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Bus request
	input  wire logic wb_cyc_i,
	input  wire logic wb_stb_i,
	// Handshake outputs
	output logic      wb_ack_o,
	output logic      req_first_o,
	output logic      req_done_o
);

	logic ack_reg;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
		end
	end

	assign wb_ack_o    = ack_reg;
	assign req_first_o = wb_cyc_i && wb_stb_i && !ack_reg;
	assign req_done_o  = wb_cyc_i && wb_stb_i && ack_reg;

endmodule : rac_wb_slave

// file: hw/rac_unused_placeholder_none.sv
// Intentionally empty file holding no module
`timescale 1ns/1ps

// file: tb/rac_alarm_flags_monitor.sv
// Checker of bus handshake and interrupt timing for the alarm flag block
`timescale 1ns/1ps
module rac_alarm_flags_monitor (
	// Clock and resets
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        manual_rst_i,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Events and interrupts
	input wire logic        seconds_count_i,
	input wire logic        sixty_four_hz_count_i,
	input wire logic        carry_irq_o,
	input wire logic        alarm_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// Bus handshake
	a_ack_prompt: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_rdata_hold: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o) || $past(rst_i))
		else $error("read data moved without request");
	////////////////////////////////////////////////////////////////
	// Interrupt requests tied to their causes
	a_carry_irq_rise: assert property ($rose(carry_irq_o) |->
		$past(seconds_count_i || sixty_four_hz_count_i, 2) || $past(wb_ack_o && wb_we_i, 2))
		else $error("carry irq rose without cause");
	a_carry_irq_fall: assert property ($fell(carry_irq_o) |->
		$past(wb_ack_o && wb_we_i, 2) || $past(manual_rst_i, 2))
		else $error("carry irq fell without cause");
	a_alarm_irq_rise: assert property ($rose(alarm_irq_o) |->
		$past(seconds_count_i, 3) || $past(wb_ack_o && wb_we_i, 2))
		else $error("alarm irq rose without cause");
	a_alarm_irq_fall: assert property ($fell(alarm_irq_o) |->
		$past(wb_ack_o && wb_we_i, 2) || $past(manual_rst_i, 2))
		else $error("alarm irq fell without cause");
	// Main scenarios
	c_write: cover property (wb_ack_o && wb_we_i);
	c_carry: cover property ($rose(carry_irq_o));
	c_alarm: cover property ($rose(alarm_irq_o));
endmodule : rac_alarm_flags_monitor

bind rac_alarm_flags rac_alarm_flags_monitor rac_alarm_flags_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
	.manual_rst_i(manual_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .seconds_count_i(seconds_count_i),
	.sixty_four_hz_count_i(sixty_four_hz_count_i), .carry_irq_o(carry_irq_o), .alarm_irq_o(alarm_irq_o));

// file: tb/rac_alarm_flags_bench.sv
// Self-checking bench for the alarm compare and flag block
`timescale 1ns/1ps
module rac_alarm_flags_bench
	import rac_pkg::*;
;
	localparam logic [6:0] MK [6] = '{RAC_MASK_SEC, RAC_MASK_MIN, RAC_MASK_HOUR,
		RAC_MASK_WDAY, RAC_MASK_DATE, RAC_MASK_MON};
	localparam logic [7:0] CR = RAC_OFS_FLAG_CTRL;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        man_rst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [7:0]  cnt [6] = '{default: 8'h00};
	logic        evsec = 1'b0;
	logic        ev64 = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        carry_irq_o;
	logic        alarm_irq_o;
	logic [7:0]  q;
	int          error_cnt = 0;
	int          samples_checked = 0;

	rac_alarm_flags rac_alarm_flags_inst (.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(man_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .seconds_counter_i(cnt[0]), .minutes_counter_i(cnt[1]),
		.hours_counter_i(cnt[2]), .weekday_counter_i(cnt[3]), .date_counter_i(cnt[4]),
		.month_counter_i(cnt[5]), .sixty_four_hz_count_i(ev64), .seconds_count_i(evsec),
		.carry_irq_o(carry_irq_o), .alarm_irq_o(alarm_irq_o));

	// Clock, 20 ns period
	always #10 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0d ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// One classic bus cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		@(posedge clk_i);
		// Only the watchdog ends a wait for ack
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rd

	// Count-up pulses of one cycle
	task automatic ev(input logic s, input logic h);
		@(posedge clk_i);
		evsec <= s;
		ev64 <= h;
		@(posedge clk_i);
		evsec <= 1'b0;
		ev64 <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : ev

	task automatic irq(input logic c, input logic a);
		repeat (3) @(posedge clk_i);
		chk({6'h0, carry_irq_o, alarm_irq_o}, {6'h0, c, a});
	endtask : irq

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (6000) @(posedge clk_i);
		error_cnt++;
		stop_test();
	end

	// Test sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(CR, 8'h00);
		irq(1'b0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 8'(4 * i), 8'h00);
			chk({7'h0, q[7]}, 8'h00);
		end
		$display("test 1 done: reset state");
		for (int i = 0; i < 6; i++) begin
			wr(8'(4 * i), 8'hFF);
			rd(8'(4 * i), {1'b1, MK[i]});
		end
		wr(8'h1C, 8'hFF);
		rd(8'h1C, 8'h00);
		sel <= 4'h0;
		wr(RAC_OFS_MIN_ALARM, 8'h00);
		sel <= 4'hF;
		rd(RAC_OFS_MIN_ALARM, 8'hFF);
		$display("test 2 done: alarm registers");
		wr(CR, 8'hFF);
		rd(CR, 8'h98);
		irq(1'b1, 1'b0);
		wr(CR, 8'h08);
		rd(CR, 8'h08);
		irq(1'b0, 1'b0);
		ev(1'b0, 1'b1);
		rd(CR, 8'h88);
		irq(1'b0, 1'b0);
		wr(CR, 8'h10);
		ev(1'b1, 1'b0);
		rd(CR, 8'h90);
		irq(1'b1, 1'b0);
		$display("test 3 done: carry flag");
		wr(CR, 8'h08);
		wr(RAC_OFS_HOUR_ALARM, 8'h23);
		wr(RAC_OFS_DATE_ALARM, 8'h00);
		wr(RAC_OFS_MON_ALARM, 8'h00);
		wr(RAC_OFS_SEC_ALARM, 8'hB0);
		wr(RAC_OFS_MIN_ALARM, 8'h95);
		wr(RAC_OFS_WDAY_ALARM, 8'h80);
		cnt[0] <= 8'h30;
		cnt[1] <= 8'h14;
		cnt[2] <= 8'h07;
		ev(1'b1, 1'b0);
		rd(CR, 8'h88);
		irq(1'b0, 1'b0);
		cnt[1] <= 8'h15;
		for (int d = 0; d < 7; d++) begin
			wr(RAC_OFS_WDAY_ALARM, 8'(8'h80 + d));
			cnt[3] <= 8'(d);
			ev(1'b1, 1'b0);
			rd(CR, 8'h89);
			irq(1'b0, 1'b1);
			wr(CR, 8'h08);
		end
		ev(1'b1, 1'b0);
		cnt[0] <= 8'h31;
		ev(1'b1, 1'b0);
		wr(CR, 8'h09);
		rd(CR, 8'h09);
		wr(CR, 8'h08);
		rd(CR, 8'h08);
		irq(1'b0, 1'b0);
		$display("test 4 done: alarm match");
		wr(CR, 8'h19);
		cnt[0] <= 8'h30;
		ev(1'b1, 1'b0);
		rd(CR, 8'h99);
		irq(1'b1, 1'b1);
		@(posedge clk_i);
		man_rst <= 1'b1;
		@(posedge clk_i);
		man_rst <= 1'b0;
		rd(CR, 8'h80);
		wr(CR, 8'h00);
		rd(CR, 8'h00);
		irq(1'b0, 1'b0);
		rd(RAC_OFS_MIN_ALARM, 8'h95);
		$display("test 5 done: manual reset");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(CR, 8'h00);
		rd(RAC_OFS_MIN_ALARM, 8'h15);
		ev(1'b1, 1'b0);
		rd(CR, 8'h80);
		$display("test 6 done: power-on reset");
		stop_test();
	end
endmodule : rac_alarm_flags_bench
